// ---- common/tpp_pkg.sv ----
// Purpose: constants for transponder page protection and identity
// Assumes: 125 MHz pclk, APB register access
// Notes:   times in microseconds, cycle counts derived below
//
// Summary of operation
// - user array is sixteen 256-bit pages
// - 256-bit volatile scratchpad for secret or challenge
// - read protection blocks reader, not hash engine
// - write protected page never changes
// - emulation mode stores old AND new data
// - emulation only on pages without write protection
// - authenticated page needs verified code before write
// - after authentication, protection bits still decide write
// - protections per page, all clear at start
// - authentication also guards protection changes
// - data shifts out lsb first, low byte first
// - 64-bit unique id: 28-bit serial, 36 fixed
// - maker code sits in id bits 48..55
// - unique id readable for inventory and sysinfo
// - identity word: family, serial, fixed, crc
// - crc polynomial x8+x5+x4+1
// - identity word feeds hash, readable by reader
// - timed interval starts after accepted request
// - program cycle ends within 10 ms
package tpp_pkg;
    localparam int CLK_MHZ      = 125;     // pclk rate
    localparam int PROG_TIME_US = 10000;   // eeprom_program_time, longest
    localparam int HASH_TIME_US = 2000;    // hash_compute_time, longest
    localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ; // exact product
    localparam int HASH_CYC_DEF = HASH_TIME_US * CLK_MHZ; // exact product
    localparam int NPAGE        = 16;      // pages
    localparam int NBLK         = 128;     // 32-bit blocks
    localparam int NSCR         = 8;       // scratchpad words
    // register byte offsets
    localparam logic [7:0] A_ADDR   = 8'h00;
    localparam logic [7:0] A_WDATA  = 8'h04;
    localparam logic [7:0] A_CMD    = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam logic [7:0] A_RDATA  = 8'h10;
    localparam logic [7:0] A_PROT   = 8'h14;
    localparam logic [7:0] A_UID_LO = 8'h18;
    localparam logic [7:0] A_UID_HI = 8'h1C;
    localparam logic [7:0] A_RID_LO = 8'h20;
    localparam logic [7:0] A_RID_HI = 8'h24;
    localparam logic [7:0] A_SCR    = 8'h28;
    localparam logic [7:0] A_SER    = 8'h2C;
    // command bits and protection field in the command word
    localparam int CMD_WR   = 0;
    localparam int CMD_PROT = 1;
    localparam int CMD_HASH = 2;
    localparam int PF_LSB   = 4;
    // protection bits of a page
    localparam int PB_RD = 0;
    localparam int PB_WR = 1;
    localparam int PB_EM = 2;
    localparam int PB_AU = 3;
    // status bits
    localparam int ST_BUSY = 0;
    localparam int ST_ERR  = 1;
    localparam int ST_DONE = 2;
    localparam logic [3:0] PROT_RST = 4'h0;   // factory: nothing active
    localparam logic [5:0] SER_LEN  = 6'h20;  // bits per shifted word
    localparam logic [7:0] CRC_POLY = 8'h8C;  // reflected x8+x5+x4+1
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_PROG = 4'h2,
        S_PROT = 4'h4,
        S_HASH = 4'h8
    } tpp_state_t;
    // crc over 56 bits, lsb first
    function automatic logic [7:0] tpp_crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            if (c[0] ^ d[i])
                c = (c >> 1) ^ CRC_POLY;
            else
                c = c >> 1;
        end
        return c;
    endfunction
endpackage

// ---- design/tpp_core.sv ----
// Purpose: page protection, scratchpad and identity words of a transponder
// Assumes: APB slave, zero wait state, registered answers
// Notes:   long timers are parameters so simulation can shorten them
`timescale 1ns/1ns
module tpp_core
    import tpp_pkg::*;
#(
    parameter int          PROG_CYC = PROG_CYC_DEF, // program interval
    parameter int          HASH_CYC = HASH_CYC_DEF, // hash interval
    parameter logic [27:0] SERIAL   = 28'h0000001,  // chip serial
    parameter logic [7:0]  FAMILY   = 8'hA5,        // arbitrary value
    parameter logic [19:0] ID_FIX   = 20'h1C3D5,    // arbitrary value
    parameter logic [7:0]  UID_TOP  = 8'h3C,        // arbitrary value
    parameter logic [7:0]  MFG      = 8'h77,        // arbitrary value
    parameter logic [19:0] UID_MID  = 20'h00A00     // arbitrary value
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        auth_ok,
    input  wire logic [7:0]  hash_sel,
    output logic [31:0]      hash_data,
    output logic [63:0]      hash_id,
    output logic             ser_bit,
    output logic             ser_valid
);
    localparam int TW = 24; // timer width

    // elaboration check of timer sizes
    if (PROG_CYC < 1 || PROG_CYC >= 2**TW || HASH_CYC < 1 || HASH_CYC >= 2**TW)
    begin : g_chk
        $error("timer count out of range");
    end

    // identity words
    localparam logic [63:0] UID = {UID_TOP, MFG, UID_MID, SERIAL};
    localparam logic [55:0] RID_B = {ID_FIX, SERIAL, FAMILY};
    localparam logic [63:0] RID = {tpp_crc8(RID_B), RID_B};
    localparam logic [TW-1:0] PROG_LD = TW'(PROG_CYC - 1);
    localparam logic [TW-1:0] HASH_LD = TW'(HASH_CYC - 1);

    logic [31:0]     mem [NBLK];         // user array, 16 pages of 8 blocks
    logic [31:0]     scr_r [NSCR];       // scratchpad
    logic [3:0]      prot_r [NPAGE];     // protection per page
    logic [6:0]      addr_r;             // block pointer
    logic [31:0]     wdat_r;             // staged write data
    tpp_state_t      st_r;               // sequencer state
    logic [TW-1:0]   cnt_r;              // interval timer
    logic [6:0]      pblk_r;             // block being programmed
    logic [31:0]     pdat_r;             // data being programmed
    logic [3:0]      pprot_r;            // protection being added
    logic            err_r;              // sticky error
    logic            done_r;             // sticky completion
    logic [31:0]     ser_sh_r;           // shift register
    logic [5:0]      ser_cnt_r;          // bits left
    logic [31:0]     prdata_r;
    logic            pready_r;
    logic            pslverr_r;
    logic [31:0]     hash_data_r;
    logic            ser_bit_r;
    logic            ser_valid_r;
    logic [31:0]     rd_word;            // read mux
    logic            rd_bad;             // read refused

    // bus phases
    wire        setup  = psel & ~penable;
    wire        acc    = psel & penable & pready_r;
    wire        wr_acc = acc & pwrite;
    wire [3:0]  page   = addr_r[6:3];
    wire [3:0]  cur_p  = prot_r[page];
    wire        idle   = (st_r == S_IDLE);
    wire [31:0] em_val = mem[addr_r] & wdat_r;
    wire [31:0] hword  = hash_sel[7] ? scr_r[hash_sel[2:0]] : mem[hash_sel[6:0]];
    wire        au_bad = cur_p[PB_AU] & ~auth_ok;
    // command decode, refusal checks
    wire        is_cmd = pwrite & (paddr == A_CMD);
    wire        c_wr   = pwdata[CMD_WR];
    wire        c_pr   = ~c_wr & pwdata[CMD_PROT];
    wire        c_hs   = ~c_wr & ~pwdata[CMD_PROT] & pwdata[CMD_HASH];
    wire        wr_bad = c_wr & (cur_p[PB_WR] | au_bad);
    wire        pr_bad = c_pr & au_bad;
    wire        cmd_bad = ~idle | wr_bad | pr_bad;
    wire        go     = wr_acc & is_cmd & ~cmd_bad;
    wire        rej    = wr_acc & is_cmd & cmd_bad & (c_wr | c_pr | c_hs);
    wire        fin    = ~idle & (cnt_r == '0);
    wire        st_clr = wr_acc & (paddr == A_STATUS);
    wire        ser_ld = wr_acc & (paddr == A_SER);
    wire        wr_map = (paddr == A_ADDR) | (paddr == A_WDATA) | (paddr == A_CMD)
                       | (paddr == A_STATUS) | (paddr == A_SCR) | (paddr == A_SER);

    // read mux and refusal
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_bad  = 1'b0;
        if (paddr == A_ADDR)
            rd_word = {25'h0000000, addr_r};
        else if (paddr == A_WDATA)
            rd_word = wdat_r;
        else if (paddr == A_CMD)
            rd_word = 32'h00000000;
        else if (paddr == A_STATUS)
            rd_word = {29'h00000000, done_r, err_r, ~idle};
        else if (paddr == A_RDATA)
        begin
            // hidden from the reader when read protected
            rd_bad  = cur_p[PB_RD];
            rd_word = cur_p[PB_RD] ? 32'h00000000 : mem[addr_r];
        end
        else if (paddr == A_PROT)
            rd_word = {28'h0000000, cur_p};
        else if (paddr == A_UID_LO)
            rd_word = UID[31:0];
        else if (paddr == A_UID_HI)
            rd_word = UID[63:32];
        else if (paddr == A_RID_LO)
            rd_word = RID[31:0];
        else if (paddr == A_RID_HI)
            rd_word = RID[63:32];
        else if (paddr == A_SCR)
            rd_word = scr_r[addr_r[2:0]];
        else if (paddr == A_SER)
            rd_word = {26'h0000000, ser_cnt_r};
        else
            rd_bad = 1'b1;
    end

    // apb answer, registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            pready_r  <= 1'b1;
            prdata_r  <= pwrite ? 32'h00000000 : rd_word;
            pslverr_r <= pwrite ? (~wr_map | (is_cmd & cmd_bad)) : rd_bad;
        end
        else if (acc)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // pointer, staging and scratchpad writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_r <= 7'h00;
            wdat_r <= 32'h00000000;
            for (int i = 0; i < NSCR; i++)
                scr_r[i] <= 32'h00000000;
        end
        else if (wr_acc)
        begin
            if (paddr == A_ADDR)
                addr_r <= pwdata[6:0];
            else if (paddr == A_WDATA)
                wdat_r <= pwdata;
            else if (paddr == A_SCR)
                scr_r[addr_r[2:0]] <= pwdata;
        end
    end

    // sequencer for program, protection and hash intervals
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= S_IDLE;
            cnt_r   <= '0;
            pblk_r  <= 7'h00;
            pdat_r  <= 32'h00000000;
            pprot_r <= 4'h0;
        end
        else
        begin
            case (st_r)
                S_IDLE:
                begin
                    if (go & c_wr)
                    begin
                        // protection still decides the stored value
                        st_r   <= S_PROG;
                        cnt_r  <= PROG_LD;
                        pblk_r <= addr_r;
                        pdat_r <= cur_p[PB_EM] ? em_val : wdat_r;
                    end
                    else if (go & c_pr)
                    begin
                        st_r    <= S_PROT;
                        cnt_r   <= PROG_LD;
                        pprot_r <= pwdata[PF_LSB +: 4];
                    end
                    else if (go & c_hs)
                    begin
                        st_r  <= S_HASH;
                        cnt_r <= HASH_LD;
                    end
                end
                S_PROG, S_PROT, S_HASH:
                begin
                    // count down, leave when the interval ends
                    if (fin)
                        st_r <= S_IDLE;
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // array commit at the end of the program interval
    always_ff @(posedge pclk)
    begin
        if (fin && st_r == S_PROG)
            mem[pblk_r] <= pdat_r;
    end

    // protections only accumulate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NPAGE; i++)
                prot_r[i] <= PROT_RST;
        end
        else if (fin && st_r == S_PROT)
            prot_r[page] <= prot_r[page] | pprot_r;
    end

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_r  <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            err_r  <= rej | (err_r & ~(st_clr & pwdata[ST_ERR]));
            done_r <= fin | (done_r & ~(st_clr & pwdata[ST_DONE]));
        end
    end

    // internal hash read port ignores read protection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hash_data_r <= 32'h00000000;
        else
            hash_data_r <= hword;
    end

    // serializer, lsb first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ser_sh_r    <= 32'h00000000;
            ser_cnt_r   <= 6'h00;
            ser_bit_r   <= 1'b0;
            ser_valid_r <= 1'b0;
        end
        else if (ser_ld)
        begin
            ser_sh_r    <= pwdata;
            ser_cnt_r   <= SER_LEN;
            ser_valid_r <= 1'b0;
        end
        else
        begin
            ser_valid_r <= (ser_cnt_r != 6'h00);
            ser_bit_r   <= ser_sh_r[0];
            if (ser_cnt_r != 6'h00)
            begin
                ser_sh_r  <= ser_sh_r >> 1;
                ser_cnt_r <= ser_cnt_r - 1'b1;
            end
        end
    end

    // identity word for the hash engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hash_id <= 64'h0000000000000000;
        else
            hash_id <= RID;
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign hash_data = hash_data_r;
    assign ser_bit   = ser_bit_r;
    assign ser_valid = ser_valid_r;

    // helper: length of current busy interval
    logic [TW:0] busy_len;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_len <= '0;
        else
            busy_len <= idle ? '0 : busy_len + 1'b1;
    end
    wire [63:0] prot_flat = {prot_r[15], prot_r[14], prot_r[13], prot_r[12],
                             prot_r[11], prot_r[10], prot_r[9], prot_r[8],
                             prot_r[7], prot_r[6], prot_r[5], prot_r[4],
                             prot_r[3], prot_r[2], prot_r[1], prot_r[0]};

    // checks
    property p_wp_refuse;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && is_cmd && idle && c_wr && cur_p[PB_WR]) |=> (st_r == S_IDLE) && err_r;
    endproperty
    a_wp_refuse: assert property (p_wp_refuse) else $error("protected write started");

    property p_em_and;
        @(posedge pclk) disable iff (!presetn)
        (go && c_wr && cur_p[PB_EM]) |=> (pdat_r == $past(em_val));
    endproperty
    a_em_and: assert property (p_em_and) else $error("emulation data not anded");

    property p_rp_hide;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == A_RDATA && cur_p[PB_RD]) |=> pslverr_r && (prdata_r == 32'h0);
    endproperty
    a_rp_hide: assert property (p_rp_hide) else $error("protected page read out");

    property p_hash_rd;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (hash_data_r == $past(hword));
    endproperty
    a_hash_rd: assert property (p_hash_rd) else $error("hash port stale");

    property p_auth;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && is_cmd && idle && (c_wr || c_pr) && au_bad) |=> (st_r == S_IDLE) ##1 (st_r == S_IDLE);
    endproperty
    a_auth: assert property (p_auth) else $error("unauthenticated change started");

    property p_prot_keep;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((prot_flat & $past(prot_flat)) == $past(prot_flat));
    endproperty
    a_prot_keep: assert property (p_prot_keep) else $error("protection cleared");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        go |=> !idle && (cnt_r == ($past(c_hs) ? HASH_LD : PROG_LD));
    endproperty
    a_start: assert property (p_start) else $error("interval did not start");

    property p_prog_len;
        @(posedge pclk) disable iff (!presetn)
        (st_r == S_PROG || st_r == S_PROT) |-> (busy_len < (TW+1)'(PROG_CYC));
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program interval too long");

    property p_uid_mfg;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == A_UID_HI) |=> (prdata_r[23:16] == MFG);
    endproperty
    a_uid_mfg: assert property (p_uid_mfg) else $error("maker code misplaced");

    property p_ser;
        @(posedge pclk) disable iff (!presetn)
        ser_ld |=> ##1 (ser_bit_r == $past(pwdata[0], 2)) && ser_valid_r;
    endproperty
    a_ser: assert property (p_ser) else $error("first bit not lsb");

    property p_err;
        @(posedge pclk) disable iff (!presetn)
        rej |=> err_r;
    endproperty
    a_err: assert property (p_err) else $error("refusal not flagged");

    // main scenarios
    c_prog: cover property (@(posedge pclk) disable iff (!presetn) (st_r == S_PROG) ##1 idle);
    c_prot: cover property (@(posedge pclk) disable iff (!presetn) (st_r == S_PROT) ##1 idle);
    c_rej:  cover property (@(posedge pclk) disable iff (!presetn) rej);
    c_ser:  cover property (@(posedge pclk) disable iff (!presetn) ser_ld ##2 ser_valid_r);
endmodule

// ---- dv/tpp_core_bench.sv ----
// Purpose: self-checking bench for tpp_core
// Assumes: short program and hash intervals
// Notes:   registers reached by APB tasks, hash side by the model
`timescale 1ns/1ns
module tpp_core_bench
    import tpp_pkg::*;
;
    localparam int          PROG = 20;             // shortened program interval
    localparam int          HASH = 10;             // shortened hash interval
    localparam logic [27:0] SER_NO = 28'h0000001;  // arbitrary serial
    localparam logic [7:0]  FAM = 8'hA5;           // arbitrary family code
    localparam logic [19:0] IDF = 20'h1C3D5;       // arbitrary fixed field
    localparam logic [7:0]  UTOP = 8'h3C;          // arbitrary top byte
    localparam logic [7:0]  UMFG = 8'h77;          // arbitrary maker code
    localparam logic [19:0] UMID = 20'h00A00;      // arbitrary middle field
    localparam logic [63:0] UID_X = {UTOP, UMFG, UMID, SER_NO};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        mac_good, auth_ok, ser_bit, ser_valid;
    logic [7:0]  paddr, want_sel, hash_sel;
    logic [31:0] pwdata, prdata, rd, hash_data, got_word, ser_word;
    logic [63:0] hash_id, rid_x;
    int          n_mismatch, checks_done, cyc;

    // crc over 56 bits, lsb first, reflected x8+x5+x4+1
    function automatic logic [7:0] crc_ref(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        end
        return c;
    endfunction
    assign rid_x = {crc_ref({IDF, SER_NO, FAM}), IDF, SER_NO, FAM};

    tpp_core #(.PROG_CYC(PROG), .HASH_CYC(HASH), .SERIAL(SER_NO), .FAMILY(FAM), .ID_FIX(IDF),
        .UID_TOP(UTOP), .MFG(UMFG), .UID_MID(UMID)) tpp_core_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .auth_ok(auth_ok), .hash_sel(hash_sel), .hash_data(hash_data),
        .hash_id(hash_id), .ser_bit(ser_bit), .ser_valid(ser_valid));
    tpp_reader_model tpp_reader_model_i (.pclk(pclk), .presetn(presetn), .mac_good(mac_good),
        .want_sel(want_sel), .hash_data(hash_data), .ser_bit(ser_bit), .ser_valid(ser_valid),
        .auth_ok(auth_ok), .hash_sel(hash_sel), .got_word(got_word), .ser_word(ser_word));

    always #4 pclk = ~pclk;

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, far above the fewer than one thousand cycles the tests need
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 8000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    // one APB transfer: setup, access until pready, then release
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // wait for the answer; only the hang guard ends a missing one
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // command on block blk; e says whether it must be refused
    task op(input logic [6:0] blk, input logic [31:0] wd, input logic [31:0] c, input logic e);
        int k;
        apb(1'h1, A_ADDR, {25'h0, blk});
        apb(1'h1, A_WDATA, wd);
        apb(1'h1, A_CMD, c);
        chk({31'h0, er}, {31'h0, e});
        k = 0;
        do
        begin
            apb(1'h0, A_STATUS, 32'h0);
            k++;
        end
        while (rd[ST_BUSY] !== 1'h0 && k < 64);
        chk({29'h0, rd[2:0]}, {29'h0, ~e, e, 1'h0});
        apb(1'h1, A_STATUS, 32'h6);
    endtask

    task rdblk(input logic [6:0] blk);
        apb(1'h1, A_ADDR, {25'h0, blk});
        apb(1'h0, A_RDATA, 32'h0);
    endtask

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, mac_good, want_sel} = '0;
        {n_mismatch, checks_done, cyc} = '0;
        want_sel = 8'h80;   // scratchpad word 0, defined from reset on
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, A_STATUS, 32'h0);
        chk(rd, 32'h0);
        for (int p = 0; p < 16; p++)
        begin
            apb(1'h1, A_ADDR, {25'h0, p[3:0], 3'h0});
            apb(1'h0, A_PROT, 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'h0, A_UID_LO, 32'h0);
        chk(rd, UID_X[31:0]);
        apb(1'h0, A_UID_HI, 32'h0);
        chk(rd, UID_X[63:32]);
        apb(1'h0, A_RID_LO, 32'h0);
        chk(rd, rid_x[31:0]);
        apb(1'h0, A_RID_HI, 32'h0);
        chk(rd, rid_x[63:32]);
        chk(hash_id[31:0], rid_x[31:0]);
        chk(hash_id[63:32], rid_x[63:32]);
        apb(1'h0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("end of test: ids and reset state");
        apb(1'h1, A_ADDR, 32'h7);
        apb(1'h1, A_SCR, 32'h5AA5_0FF0);
        apb(1'h0, A_SCR, 32'h0);
        chk(rd, 32'h5AA5_0FF0);
        want_sel <= 8'h87;
        repeat (4) @(posedge pclk);
        chk(got_word, 32'h5AA5_0FF0);
        $display("end of test: scratchpad");
        apb(1'h1, A_ADDR, 32'h7F);
        apb(1'h1, A_WDATA, 32'hF0F0_A55A);
        apb(1'h1, A_CMD, 32'h1);
        apb(1'h0, A_STATUS, 32'h0);
        chk({31'h0, rd[ST_BUSY]}, 32'h1);
        apb(1'h1, A_CMD, 32'h1);
        chk({31'h0, er}, 32'h1);
        repeat (PROG) @(posedge pclk);
        apb(1'h0, A_STATUS, 32'h0);
        chk(rd, 32'h6);
        apb(1'h1, A_STATUS, 32'h6);
        rdblk(7'h7F);
        chk(rd, 32'hF0F0_A55A);
        op(7'h00, 32'hF0F0_A55A, 32'h1, 1'h0);
        op(7'h00, 32'h0, 32'h42, 1'h0);
        op(7'h00, 32'h0FF0_FFFF, 32'h1, 1'h0);
        rdblk(7'h00);
        chk(rd, 32'h00F0_A55A);
        op(7'h00, 32'h0, 32'h4, 1'h0);
        $display("end of test: program, busy, emulation, hash");
        op(7'h08, 32'h1234_5678, 32'h1, 1'h0);
        op(7'h08, 32'h0, 32'h62, 1'h0);
        op(7'h08, 32'h0, 32'h1, 1'h1);
        rdblk(7'h08);
        chk(rd, 32'h1234_5678);
        apb(1'h0, A_PROT, 32'h0);
        chk(rd, 32'h6);
        op(7'h10, 32'hCAFE_0001, 32'h1, 1'h0);
        op(7'h10, 32'h0, 32'h12, 1'h0);
        rdblk(7'h10);
        chk({rd[31:1], er}, 32'h1);
        want_sel <= 8'h10;
        repeat (4) @(posedge pclk);
        chk(got_word, 32'hCAFE_0001);
        $display("end of test: write and read protection");
        op(7'h18, 32'h0, 32'h82, 1'h0);
        op(7'h18, 32'h0000_00FF, 32'h1, 1'h1);
        op(7'h18, 32'h0, 32'h42, 1'h1);
        mac_good <= 1'h1;
        op(7'h18, 32'h0000_00FF, 32'h1, 1'h0);
        op(7'h18, 32'h0, 32'h42, 1'h0);
        op(7'h18, 32'h0000_F00F, 32'h1, 1'h0);
        rdblk(7'h18);
        chk(rd, 32'h0000_000F);
        apb(1'h0, A_PROT, 32'h0);
        chk(rd, 32'hC);
        mac_good <= 1'h0;
        $display("end of test: authentication");
        apb(1'h1, A_SER, 32'h1357_9BDF);
        repeat (40) @(posedge pclk);
        chk(ser_word, 32'h1357_9BDF);
        apb(1'h0, A_SER, 32'h0);
        chk(rd, 32'h0);
        $display("end of test: serial order");
        tally_and_finish;
    end
endmodule

// ---- dv/tpp_reader_model.sv ----
// Purpose: reader and hash-engine side model for tpp_core
// Assumes: one clock, every hand-off registered
// Notes:   the bench decides per scenario whether the reader code is good
`timescale 1ns/1ns
module tpp_reader_model
    import tpp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mac_good,   // bench: reader code verified
    input  wire logic [7:0]  want_sel,   // bench: word the hash engine wants
    input  wire logic [31:0] hash_data,
    input  wire logic        ser_bit,
    input  wire logic        ser_valid,
    output logic             auth_ok,
    output logic [7:0]       hash_sel,
    output logic [31:0]      got_word,
    output logic [31:0]      ser_word
);
    // verdict, hash selection and captures, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auth_ok  <= 1'h0;
            hash_sel <= 8'h80;  // scratchpad, never an unwritten block
            got_word <= 32'h0;
            ser_word <= 32'h0;
        end
        else
        begin
            auth_ok  <= mac_good;
            hash_sel <= want_sel;
            got_word <= hash_data;
            // first bit lands lowest after all shifts
            if (ser_valid)
                ser_word <= {ser_bit, ser_word[31:1]};
        end
    end
endmodule
